/* File: trl_map.vh */
// register map, field positions, reset values and timing figures of the temperature readout logic
// assumes a 100 MHz system clock and word-indexed APB addressing
`ifndef TRL_MAP_VH
`define TRL_MAP_VH

// register indices; byte address is four times the index
`define TRL_IDX_CONFIG_ONE 8'h00
`define TRL_IDX_CONFIG_THREE 8'h07
`define TRL_IDX_LOCAL_TEMP 8'h1F
`define TRL_IDX_AUX_EIGHT 8'h27
`define TRL_IDX_SECOND_DIODE 8'h29
`define TRL_IDX_FIRST_DIODE 8'h30
`define TRL_IDX_STATUS 8'h31

// field positions
`define TRL_CFG1_START_BIT 0
`define TRL_CFG1_AUX_MODE_BIT 3
`define TRL_CFG3_REF_HIGH_BIT 2

// reset values
`define TRL_CONFIG_ONE_RST 8'h00
`define TRL_CONFIG_THREE_RST 8'h00
`define TRL_RESULT_RST 8'h00
`define TRL_NO_RESULT 8'h00

// measurement channels in round-robin order
`define TRL_CH_FIRST_DIODE 3'h0
`define TRL_CH_SECOND_DIODE 3'h1
`define TRL_CH_AUX_EIGHT 3'h2
`define TRL_CH_AUX_NINE 3'h3
`define TRL_CH_LOCAL 3'h4

// averaging depth
`define TRL_AVG_SAMPLES 16
`define TRL_AVG_LAST 4'hF

// timing figures
`define TRL_CLK_PERIOD_NS 10
`define TRL_REMOTE_SLOT_NS 2140000
`define TRL_ANALOG_SLOT_NS 711000
// slot lengths in clock cycles at 100 MHz, sized to the slot counter
`define TRL_REMOTE_SLOT_CYC 18'h343F0
`define TRL_ANALOG_SLOT_CYC 18'h115BC

`endif

/* File: trl_avg.v */
// sixteen-sample averager for one 8-bit conversion stream
// assumes samples arrive as single-cycle strobes from the sequencer
`timescale 1ns/10ps
`include "trl_map.vh"

module trl_avg (
  input wire clk,
  input wire rst,
  input wire clear,
  input wire sample_valid,
  input wire [7:0] sample,
  input wire is_signed,
  output reg [7:0] avg_reg,
  output reg done_reg
);

  reg [11:0] acc_reg;
  reg [3:0] count_reg;
  wire [11:0] sample_ext;
  wire [11:0] acc_next;

  // diode and local codes are twos complement, aux inputs are unsigned
  assign sample_ext = is_signed ? {{4{sample[7]}}, sample} : {4'h0, sample};
  assign acc_next = acc_reg + sample_ext;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= 12'h000;
      count_reg <= 4'h0;
      avg_reg <= `TRL_RESULT_RST;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (clear) begin
        acc_reg <= 12'h000;
        count_reg <= 4'h0;
      end else if (sample_valid) begin
        if (count_reg == `TRL_AVG_LAST) begin
          // sum of 16 fits 12 bits; dropping 4 lsbs divides by 16
          avg_reg <= acc_next[11:4];
          done_reg <= 1'b1;
          acc_reg <= 12'h000;
          count_reg <= 4'h0;
        end else begin
          acc_reg <= acc_next;
          count_reg <= count_reg + 4'h1;
        end
      end
    end
  end

endmodule

/* File: trl_readout.v */
// temperature readout logic: APB register file, round-robin sequencer, diode bias control
// assumes a synchronous ADC whose adc_data is valid whenever a slot ends
//
// Functional notes
// - The local sensor's averaged result is written as twos complement into the local temperature register.
// - Temperature results are 8-bit codes, one per degree, spanning -128 to +127 degrees; aux results are unsigned codes.
// - Config one bit 3 at 0 makes the shared pins the second diode channel, at 1 two aux analog inputs.
// - Every result is the average of 16 consecutive conversions.
// - Each remote conversion gets a slot of nominally 2.14 ms.
// - Remote results are stored as 8-bit twos complement, 80h lowest, 00h zero, 7Fh highest.
// - Config three bit 2 selects the reference level, 0 for 1.82 V and 1 for 2.5 V.
// - During each remote conversion the diode bias alternates between base and multiplied current.
// - In diode mode the second diode result goes to 29h and 27h holds no valid result.
// - Writing the start bit begins round-robin measuring, which runs until the bit is cleared.
`timescale 1ns/10ps
`include "trl_map.vh"

module trl_readout #(
  parameter [17:0] REMOTE_SLOT_CYC = `TRL_REMOTE_SLOT_CYC,
  parameter [17:0] ANALOG_SLOT_CYC = `TRL_ANALOG_SLOT_CYC
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] adc_data,
  output reg conv_start_reg,
  output reg [2:0] meas_channel_reg,
  output reg bias_high_reg,
  output reg aux_mode_reg,
  output reg ref_high_reg
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state_reg;
  reg [2:0] ch_reg;
  reg [17:0] slot_cnt_reg;
  reg [7:0] config_one_reg;
  reg [7:0] config_three_reg;
  reg [7:0] local_temp_reg;
  reg [7:0] first_diode_reg;
  reg [7:0] second_diode_reg;
  reg [7:0] aux_eight_reg;
  reg [7:0] aux_nine_reg;
  reg [31:0] rdata_next;
  reg err_next;

  wire [7:0] avg_value;
  wire avg_done;
  wire running;
  wire is_remote;
  wire [17:0] slot_len;
  wire slot_end;
  wire aux_mode;
  wire [9:0] word_idx;
  wire setup_phase;
  wire wr_access;

  assign running = (state_reg == ST_RUN);
  assign is_remote = (ch_reg == `TRL_CH_FIRST_DIODE) || (ch_reg == `TRL_CH_SECOND_DIODE);
  assign slot_len = is_remote ? REMOTE_SLOT_CYC : ANALOG_SLOT_CYC;
  assign slot_end = running && (slot_cnt_reg == slot_len - 18'd1);
  assign aux_mode = config_one_reg[`TRL_CFG1_AUX_MODE_BIT];
  assign word_idx = paddr[11:2];
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pready && pwrite;

  // aux inputs are unsigned voltages; every other channel is a temperature
  trl_avg u_avg (
    .clk(clk),
    .rst(rst),
    .clear(!running),
    .sample_valid(slot_end),
    .sample(adc_data),
    .is_signed(ch_reg != `TRL_CH_AUX_EIGHT && ch_reg != `TRL_CH_AUX_NINE),
    .avg_reg(avg_value),
    .done_reg(avg_done)
  );

  // sequencer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      ch_reg <= `TRL_CH_FIRST_DIODE;
      slot_cnt_reg <= 18'd0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          ch_reg <= `TRL_CH_FIRST_DIODE;
          slot_cnt_reg <= 18'd0;
          if (config_one_reg[`TRL_CFG1_START_BIT]) begin
            state_reg <= ST_RUN;
          end
        end
        default: begin
          if (!config_one_reg[`TRL_CFG1_START_BIT]) begin
            state_reg <= ST_IDLE;
          end else if (avg_done) begin
            slot_cnt_reg <= 18'd0;
            ch_reg <= (ch_reg == `TRL_CH_LOCAL) ? `TRL_CH_FIRST_DIODE : ch_reg + 3'h1;
          end else if (slot_end) begin
            slot_cnt_reg <= 18'd0;
          end else begin
            slot_cnt_reg <= slot_cnt_reg + 18'd1;
          end
        end
      endcase
    end
  end

  // front-end control, all registered
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_start_reg <= 1'b0;
      meas_channel_reg <= `TRL_CH_FIRST_DIODE;
      bias_high_reg <= 1'b0;
      aux_mode_reg <= 1'b0;
      ref_high_reg <= 1'b0;
    end else begin
      // none in the channel-change cycle, else a stray launch on the old channel
      conv_start_reg <= running && (slot_cnt_reg == 18'd0) && !avg_done;
      meas_channel_reg <= ch_reg;
      // base current first half of slot, multiplied current second half
      bias_high_reg <= running && is_remote && (slot_cnt_reg >= {1'b0, slot_len[17:1]});
      aux_mode_reg <= aux_mode;
      ref_high_reg <= config_three_reg[`TRL_CFG3_REF_HIGH_BIT];
    end
  end

  // result store: only on a completed average, so reads never see partial sums
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      local_temp_reg <= `TRL_RESULT_RST;
      first_diode_reg <= `TRL_RESULT_RST;
      second_diode_reg <= `TRL_RESULT_RST;
      aux_eight_reg <= `TRL_RESULT_RST;
      aux_nine_reg <= `TRL_RESULT_RST;
    end else if (avg_done && running) begin
      case (ch_reg)
        `TRL_CH_FIRST_DIODE: begin
          first_diode_reg <= avg_value;
        end
        `TRL_CH_SECOND_DIODE: begin
          // measured in both modes, discarded when the pins are aux inputs
          if (!aux_mode) begin
            second_diode_reg <= avg_value;
          end
        end
        `TRL_CH_AUX_EIGHT: begin
          if (aux_mode) begin
            aux_eight_reg <= avg_value;
          end
        end
        `TRL_CH_AUX_NINE: begin
          if (aux_mode) begin
            aux_nine_reg <= avg_value;
          end
        end
        default: begin
          local_temp_reg <= avg_value;
        end
      endcase
    end
  end

  // read mux; 8-bit codes in low bits keep the full -128..+127 range
  always @* begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    if (word_idx == {2'b00, `TRL_IDX_CONFIG_ONE}) begin
      rdata_next[7:0] = config_one_reg;
    end else if (word_idx == {2'b00, `TRL_IDX_CONFIG_THREE}) begin
      rdata_next[7:0] = config_three_reg;
    end else if (word_idx == {2'b00, `TRL_IDX_LOCAL_TEMP}) begin
      rdata_next[7:0] = local_temp_reg;
    end else if (word_idx == {2'b00, `TRL_IDX_AUX_EIGHT}) begin
      rdata_next[7:0] = aux_mode ? aux_eight_reg : `TRL_NO_RESULT;
    end else if (word_idx == {2'b00, `TRL_IDX_SECOND_DIODE}) begin
      rdata_next[7:0] = aux_mode ? aux_nine_reg : second_diode_reg;
    end else if (word_idx == {2'b00, `TRL_IDX_FIRST_DIODE}) begin
      rdata_next[7:0] = first_diode_reg;
    end else if (word_idx == {2'b00, `TRL_IDX_STATUS}) begin
      rdata_next[3:0] = {ch_reg, state_reg};
    end else begin
      err_next = 1'b1;
    end
  end

  // APB slave: one wait-free access phase, pready raised from the setup cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      if (setup_phase) begin
        pslverr <= err_next;
        prdata <= pwrite ? 32'h0000_0000 : rdata_next;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      config_one_reg <= `TRL_CONFIG_ONE_RST;
      config_three_reg <= `TRL_CONFIG_THREE_RST;
    end else if (wr_access) begin
      if (word_idx == {2'b00, `TRL_IDX_CONFIG_ONE}) begin
        config_one_reg <= pwdata[7:0];
      end else if (word_idx == {2'b00, `TRL_IDX_CONFIG_THREE}) begin
        config_three_reg <= pwdata[7:0];
      end
    end
  end

endmodule

/* File: trl_chk_checker.sv */
// concurrent checks on the readout block's bus and sequencer ports
// bound to every trl_readout instance; sees its ports only
`timescale 1ns/10ps
module trl_chk (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] adc_data,
  input wire conv_start_reg,
  input wire [2:0] meas_channel_reg,
  input wire bias_high_reg,
  input wire aux_mode_reg,
  input wire ref_high_reg
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  wire cfg_wr = psel && penable && pready && pwrite;
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready |-> pslverr == !(paddr[11:2] inside {10'h0, 10'h7, 10'h1F, 10'h27,
    10'h29, 10'h30, 10'h31})) else $error("error flag wrong");
  a_rd_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_aux_follows: assert property (cfg_wr && paddr[11:2] == 10'h0 |-> ##2 aux_mode_reg == $past(pwdata[3], 2))
    else $error("aux mode not following config");
  a_ref_follows: assert property (cfg_wr && paddr[11:2] == 10'h7 |-> ##2 ref_high_reg == $past(pwdata[2], 2))
    else $error("reference select not following config");
  a_stop_halts: assert property (cfg_wr && paddr[11:2] == 10'h0 && !pwdata[0] |-> ##3 !conv_start_reg[*8])
    else $error("conversions after stop");
  a_bias_remote_only: assert property (bias_high_reg |-> meas_channel_reg <= 3'h1)
    else $error("bias raised on a non diode channel");
  a_bias_toggles: assert property (bias_high_reg |-> ##[1:8] !bias_high_reg)
    else $error("bias never returns to base current");
  a_start_pulse: assert property (conv_start_reg |=> !conv_start_reg)
    else $error("start pulse too long");
endmodule
bind trl_readout trl_chk u_chk (.*);

/* File: trl_adc_model.sv */
// behavioural converter: a ramp of sixteen codes above a per-channel base
// assumes the sequencer samples adc_data on the last cycle of each slot
`timescale 1ns/10ps
module trl_adc_model (
  input wire clk,
  input wire rst,
  input wire conv_start,
  input wire [2:0] channel,
  output wire [7:0] adc_data
);
  reg [3:0] step_reg;
  reg [7:0] base;
  always @* begin
    case (channel)
      3'h0: base = 8'h80;
      3'h1, 3'h2: base = 8'h78;
      3'h3: base = 8'h00;
      default: base = 8'h70;
    endcase
  end
  // any sixteen consecutive steps sum alike, so an abort cannot skew a later average
  always @(posedge clk or posedge rst) begin
    if (rst) step_reg <= 4'h0;
    else if (conv_start) step_reg <= step_reg + 4'h1;
  end
  // code not settled while a conversion is launched
  assign adc_data = conv_start ? ~(base + step_reg) : base + step_reg;
endmodule

/* File: test_temperature_readout_logic.sv */
// self-checking bench for trl_readout with a ramp converter model
// assumes shortened slots so one round takes a few hundred cycles
`timescale 1ns/10ps
`include "trl_map.vh"
module test_temperature_readout_logic;
  reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, wd;
  wire [31:0] prdata;
  wire pready, pslverr, conv_start, bias_high, aux_mode, ref_high;
  wire [2:0] meas_ch;
  wire [7:0] adc_data;
  integer seed = 52344, n_errors = 0, comparisons = 0, cycles = 0, i;
  reg [32:0] q[$];
  always #5 clk = ~clk;
  trl_readout #(.REMOTE_SLOT_CYC(18'd8), .ANALOG_SLOT_CYC(18'd4)) u_dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_data(adc_data), .conv_start_reg(conv_start), .meas_channel_reg(meas_ch),
    .bias_high_reg(bias_high), .aux_mode_reg(aux_mode), .ref_high_reg(ref_high));
  trl_adc_model u_adc (.clk(clk), .rst(rst), .conv_start(conv_start), .channel(meas_ch), .adc_data(adc_data));
  task check(input [32:0] seen, input [32:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task apb(input w, input [9:0] idx, input [31:0] d, input err, input [7:0] rd);
    begin
      @(posedge clk);
      q.push_back({err, 24'h0, rd});
      psel <= 1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
    end
  endtask
  task wait_ch(input [2:0] ch);
    begin
      i = 0;
      while (meas_ch !== ch && i < 2000) begin
        @(posedge clk);
        i = i + 1;
      end
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      conclude;
    end else if (psel && penable && pready === 1'b1) begin
      check({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    apb(0, `TRL_IDX_CONFIG_ONE, 0, 0, `TRL_CONFIG_ONE_RST);
    apb(0, `TRL_IDX_CONFIG_THREE, 0, 0, `TRL_CONFIG_THREE_RST);
    wd = $random(seed);
    apb(1, `TRL_IDX_CONFIG_THREE, wd, 0, 0);
    apb(0, `TRL_IDX_CONFIG_THREE, 0, 0, wd[7:0]);
    wd = $random(seed) & 32'hFE;
    apb(1, `TRL_IDX_CONFIG_ONE, wd, 0, 0);
    apb(0, `TRL_IDX_CONFIG_ONE, 0, 0, wd[7:0]);
    apb(0, 10'h8, 0, 1, 0);
    apb(1, 10'h3FF, wd, 1, 0);
    // diode mode: ramp averages with floor, signed wrap on the second diode
    apb(1, `TRL_IDX_CONFIG_ONE, 1, 0, 0);
    wait_ch(4);
    wait_ch(0);
    repeat (4) @(posedge clk);
    apb(0, `TRL_IDX_FIRST_DIODE, 0, 0, 8'h87);
    apb(0, `TRL_IDX_SECOND_DIODE, 0, 0, 8'hFF);
    apb(0, `TRL_IDX_AUX_EIGHT, 0, 0, `TRL_NO_RESULT);
    apb(1, `TRL_IDX_LOCAL_TEMP, 32'hFF, 0, 0);
    apb(0, `TRL_IDX_LOCAL_TEMP, 0, 0, 8'h77);
    // aux mode: same codes averaged unsigned
    apb(1, `TRL_IDX_CONFIG_ONE, 9, 0, 0);
    wait_ch(4);
    wait_ch(0);
    repeat (4) @(posedge clk);
    apb(0, `TRL_IDX_AUX_EIGHT, 0, 0, 8'h7F);
    apb(0, `TRL_IDX_SECOND_DIODE, 0, 0, 8'h07);
    apb(1, `TRL_IDX_CONFIG_ONE, 8, 0, 0);
    repeat (20) @(posedge clk);
    // abort in mid second diode: partial average must not land
    apb(1, `TRL_IDX_CONFIG_ONE, 1, 0, 0);
    wait_ch(1);
    repeat (40) @(posedge clk);
    apb(1, `TRL_IDX_CONFIG_ONE, 0, 0, 0);
    repeat (20) @(posedge clk);
    // diode mode again: 29h shows the last full diode average, not the aux value
    apb(0, `TRL_IDX_SECOND_DIODE, 0, 0, 8'hFF);
    apb(0, `TRL_IDX_FIRST_DIODE, 0, 0, 8'h87);
    // stopped: idle with the channel back at the first diode
    apb(0, `TRL_IDX_STATUS, 0, 0, 8'h00);
    repeat (2) @(posedge clk);
    conclude;
  end
endmodule
